// ==== rtl/flash_read_params.svh ====
`ifndef FLASH_READ_PARAMS_SVH
`define FLASH_READ_PARAMS_SVH

// ==========================================================================
// Opcodes decoded by the read engine
`define OPC_FAST_READ 8'h0B
`define OPC_DUAL_OUT 8'h3B
`define OPC_QUAD_OUT 8'h6B
`define OPC_DUAL_IO 8'hBB
`define OPC_QUAD_IO 8'hEB
`define OPC_QUAD_WORD 8'hE7
`define OPC_CRM_RESET 8'hFF

// ==========================================================================
// Continuous-mode byte: upper nibble that keeps the opcode skipped
`define CRM_KEEP_NIBBLE 4'hA

// ==========================================================================
// Phase lengths in link clocks, minus one where noted
`define OPCODE_LAST 5'h07
`define ADDR_LAST_X1 5'h17
`define ADDR_LAST_X2 5'h0B
`define ADDR_LAST_X4 5'h05
`define MODE_LAST_X2 5'h03
`define MODE_LAST_X4 5'h01
`define DUMMY_CLKS_BYTE 5'h08
`define DUMMY_CLKS_DUAL_IO 5'h00
`define DUMMY_CLKS_QUAD_IO 5'h04
`define DUMMY_CLKS_QUAD_WORD 5'h02
`define DATA_LAST_X1 5'h07
`define DATA_LAST_X2 5'h03
`define DATA_LAST_X4 5'h01

// ==========================================================================
// Wrap configuration {quad_enable, wrap_disable, wrap_length[1:0]}
`define CFG_RESET 4'h4
`define CFG_QE_BIT 3
`define CFG_WDIS_BIT 2
`define CFG_WLEN_HI 1
`define CFG_WLEN_LO 0
`define WRAP_MIN_BYTES 8'h08

`endif

// ==== rtl/flash_read_pkg.sv ====
package flash_read_pkg;

    // ======================================================================
    // Read command kinds
    typedef enum logic [2:0] {
        CMD_FAST,
        CMD_DUAL_OUT,
        CMD_QUAD_OUT,
        CMD_DUAL_IO,
        CMD_QUAD_IO,
        CMD_QUAD_WORD
    } cmd_t;

    // ======================================================================
    // Frame phases on the link
    typedef enum logic [2:0] {
        PH_START,
        PH_OPCODE,
        PH_ADDR,
        PH_MODE,
        PH_DUMMY,
        PH_DATA,
        PH_IGNORE
    } phase_t;

    // ======================================================================
    // Number of lanes in use
    typedef enum logic [1:0] {
        LANE_X1,
        LANE_X2,
        LANE_X4
    } lane_mode_t;

endpackage : flash_read_pkg

// ==== rtl/lane_if.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Byte hand-off from the frame sequencer to the lane driver
interface lane_if;
    import flash_read_pkg::*;
    logic load;
    logic [7:0] byte_v;
    lane_mode_t width;

    modport ctrl (output load, output byte_v, output width);
    modport drv (input load, input byte_v, input width);
endinterface : lane_if

// ==== rtl/bit_sync.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Two-flop level synchroniser; only s2 is ever read
module bit_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic clr,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // Asynchronous clear so a stopped clock still sees a defined value
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;
endmodule : bit_sync

// ==== rtl/lane_driver.sv ====
`timescale 1ns/1ps
// ==========================================================================
// Falling-edge output shifter for one, two or four lanes
module lane_driver
    import flash_read_pkg::*;
(
    input wire logic sclk,
    input wire logic cs_n,
    lane_if.drv lif,
    output logic [3:0] lane_o,
    output logic [3:0] lane_oe
);
    logic [7:0] sh_q;
    logic [7:0] cur;
    logic drive_q;

    // Next byte or the current one shifted by the lane count
    always_comb begin
        cur = sh_q;
        if (lif.load) begin
            cur = lif.byte_v;
        end else if (drive_q) begin
            case (lif.width)
                LANE_X1: cur = {sh_q[6:0], 1'b0};
                LANE_X2: cur = {sh_q[5:0], 2'b00};
                default: cur = {sh_q[3:0], 4'h0};
            endcase
        end
    end

    // Data changes on the falling edge; chip select high frees lanes
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sh_q <= 8'h00;
            drive_q <= 1'b0;
            lane_o <= 4'h0;
            lane_oe <= 4'h0;
        end else begin
            sh_q <= cur;
            if (lif.load) begin
                drive_q <= 1'b1;
            end
            if (lif.load || drive_q) begin
                case (lif.width)
                    LANE_X1: begin
                        lane_o <= {2'b00, cur[7], 1'b0};
                        lane_oe <= 4'h2;
                    end
                    LANE_X2: begin
                        lane_o <= {2'b00, cur[7:6]};
                        lane_oe <= 4'h3;
                    end
                    default: begin
                        lane_o <= cur[7:4];
                        lane_oe <= 4'hF;
                    end
                endcase
            end
        end
    end
endmodule : lane_driver

// ==== rtl/serial_flash_fast_read_engine.sv ====
`timescale 1ns/1ps
`include "flash_read_params.svh"

module serial_flash_fast_read_engine
    import flash_read_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic quad_lane_0_i,
    output logic quad_lane_0_o,
    output logic quad_lane_0_oe,
    input wire logic quad_lane_1_i,
    output logic quad_lane_1_o,
    output logic quad_lane_1_oe,
    input wire logic quad_lane_2_i,
    output logic quad_lane_2_o,
    output logic quad_lane_2_oe,
    input wire logic quad_lane_3_i,
    output logic quad_lane_3_o,
    output logic quad_lane_3_oe,
    input wire logic quad_enable_flag,
    input wire logic wrap_disable_bit,
    input wire logic [1:0] wrap_length_field,
    input wire logic crm_clear,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic read_active,
    output logic continuous_mode_active
);

    // ======================================================================
    // Decode helpers

    // Lanes used for address, mode byte and dummy cycles
    function automatic lane_mode_t addr_lanes(input cmd_t c);
        case (c)
            CMD_DUAL_IO: addr_lanes = LANE_X2;
            CMD_QUAD_IO, CMD_QUAD_WORD: addr_lanes = LANE_X4;
            default: addr_lanes = LANE_X1;
        endcase
    endfunction : addr_lanes

    // Lanes used for read data
    function automatic lane_mode_t data_lanes(input cmd_t c);
        case (c)
            CMD_FAST: data_lanes = LANE_X1;
            CMD_DUAL_OUT, CMD_DUAL_IO: data_lanes = LANE_X2;
            default: data_lanes = LANE_X4;
        endcase
    endfunction : data_lanes

    // Dummy clocks between address or mode byte and data
    function automatic logic [4:0] dummy_clks(input cmd_t c);
        case (c)
            CMD_DUAL_IO: dummy_clks = `DUMMY_CLKS_DUAL_IO;
            CMD_QUAD_IO: dummy_clks = `DUMMY_CLKS_QUAD_IO;
            CMD_QUAD_WORD: dummy_clks = `DUMMY_CLKS_QUAD_WORD;
            default: dummy_clks = `DUMMY_CLKS_BYTE;
        endcase
    endfunction : dummy_clks

    // Only the I/O variants carry a continuous-mode byte
    function automatic logic has_mode(input cmd_t c);
        has_mode = (c == CMD_DUAL_IO) || (c == CMD_QUAD_IO) ||
                   (c == CMD_QUAD_WORD);
    endfunction : has_mode

    // Last clock count of a phase
    function automatic logic [4:0] last_clk(input phase_t p, input cmd_t c);
        case (p)
            PH_OPCODE: last_clk = `OPCODE_LAST;
            PH_ADDR: begin
                case (addr_lanes(c))
                    LANE_X1: last_clk = `ADDR_LAST_X1;
                    LANE_X2: last_clk = `ADDR_LAST_X2;
                    default: last_clk = `ADDR_LAST_X4;
                endcase
            end
            PH_MODE: begin
                if (addr_lanes(c) == LANE_X2) begin
                    last_clk = `MODE_LAST_X2;
                end else begin
                    last_clk = `MODE_LAST_X4;
                end
            end
            PH_DUMMY: last_clk = 5'(dummy_clks(c) - 5'h01);
            PH_DATA: begin
                case (data_lanes(c))
                    LANE_X1: last_clk = `DATA_LAST_X1;
                    LANE_X2: last_clk = `DATA_LAST_X2;
                    default: last_clk = `DATA_LAST_X4;
                endcase
            end
            default: last_clk = 5'h1F;
        endcase
    endfunction : last_clk

    // Shift in one, two or four lane bits, highest lane first
    function automatic logic [23:0] shift_in(input logic [23:0] v,
            input lane_mode_t m, input logic [3:0] p);
        case (m)
            LANE_X1: shift_in = {v[22:0], p[0]};
            LANE_X2: shift_in = {v[21:0], p[1:0]};
            default: shift_in = {v[19:0], p[3:0]};
        endcase
    endfunction : shift_in

    // Byte address advance, optionally wrapping in an aligned section
    function automatic logic [ADDR_W-1:0] next_addr(
            input logic [ADDR_W-1:0] a, input logic wrap_on,
            input logic [1:0] len);
        logic [7:0] mask;
        logic [7:0] low;
        mask = 8'((`WRAP_MIN_BYTES << len) - 8'h01);
        low = (a[7:0] & ~mask) | (8'(a[7:0] + 8'h01) & mask);
        if (wrap_on) begin
            next_addr = {a[ADDR_W-1:8], low};
        end else begin
            next_addr = ADDR_W'(a + 1'b1);
        end
    endfunction : next_addr

    // ======================================================================
    // System clock side: configuration and continuous-mode clear

    logic [3:0] cfg_q;
    logic link_clear_q;
    logic [1:0] stat_s;

    // Configuration held in one register so it crosses as a group
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_q <= `CFG_RESET;
        end else begin
            cfg_q <= {quad_enable_flag, wrap_disable_bit,
                      wrap_length_field};
        end
    end

    // Reset or explicit clear drops the stored continuous mode
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            link_clear_q <= 1'b1;
        end else begin
            link_clear_q <= crm_clear;
        end
    end

    // Status flags seen from the system clock
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            read_active <= 1'b0;
            continuous_mode_active <= 1'b0;
        end else begin
            read_active <= stat_s[1];
            continuous_mode_active <= stat_s[0];
        end
    end

    // ======================================================================
    // Link side: frame sequencer on the serial clock

    logic [3:0] cfg_s;
    phase_t ph_q;
    phase_t ph_d;
    phase_t eff_ph;
    cmd_t cmd_q;
    cmd_t cmd_d;
    cmd_t eff_cmd;
    cmd_t crm_cmd_q;
    logic crm_q;
    logic [4:0] cnt_q;
    logic [23:0] sh_q;
    logic [23:0] sh_d;
    logic [3:0] pins;
    lane_mode_t in_lanes;
    logic last;
    logic start_byte;
    logic mode_done;
    logic crm_kill;
    logic load_q;
    logic busy_q;
    logic [7:0] pre_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [ADDR_W-1:0] addr_full;
    logic wrap_on;

    // Configuration is quasi-static; two link edges of lag are harmless
    bit_sync #(.W(4), .RST_VAL(`CFG_RESET)) u_cfg_sync (
        .clk(sclk),
        .clr(link_clear_q),
        .d(cfg_q),
        .q(cfg_s)
    );

    // Status crosses back as levels
    bit_sync #(.W(2), .RST_VAL(2'b00)) u_stat_sync (
        .clk(mclk),
        .clr(link_clear_q),
        .d({busy_q, crm_q}),
        .q(stat_s)
    );

    assign pins = {quad_lane_3_i, quad_lane_2_i, quad_lane_1_i,
                   quad_lane_0_i};

    // First edge of a frame picks opcode or, in continuous mode, address
    assign eff_ph = (ph_q == PH_START) ? (crm_q ? PH_ADDR : PH_OPCODE)
                                       : ph_q;
    assign eff_cmd = (ph_q == PH_START) ? crm_cmd_q : cmd_q;
    assign in_lanes = (eff_ph == PH_OPCODE) ? LANE_X1 : addr_lanes(eff_cmd);
    assign sh_d = shift_in(sh_q, in_lanes, pins);
    assign last = (cnt_q == last_clk(eff_ph, eff_cmd));
    assign wrap_on = !cfg_s[`CFG_WDIS_BIT] &&
                     ((cmd_q == CMD_QUAD_IO) ||
                      (cmd_q == CMD_QUAD_WORD));

    // Word read forces the lowest address bit to zero
    always_comb begin
        addr_full = sh_d[ADDR_W-1:0];
        if (eff_cmd == CMD_QUAD_WORD) begin
            addr_full[0] = 1'b0;
        end
    end

    // Phase transitions
    always_comb begin
        ph_d = eff_ph;
        cmd_d = eff_cmd;
        start_byte = 1'b0;
        mode_done = 1'b0;
        crm_kill = 1'b0;
        case (eff_ph)
            PH_OPCODE: begin
                if (last) begin
                    ph_d = PH_ADDR;
                    case (sh_d[7:0])
                        `OPC_FAST_READ: cmd_d = CMD_FAST;
                        `OPC_DUAL_OUT: cmd_d = CMD_DUAL_OUT;
                        `OPC_QUAD_OUT: cmd_d = CMD_QUAD_OUT;
                        `OPC_DUAL_IO: cmd_d = CMD_DUAL_IO;
                        `OPC_QUAD_IO: begin
                            cmd_d = CMD_QUAD_IO;
                            if (!cfg_s[`CFG_QE_BIT]) begin
                                ph_d = PH_IGNORE;
                            end
                        end
                        `OPC_QUAD_WORD: begin
                            cmd_d = CMD_QUAD_WORD;
                            if (!cfg_s[`CFG_QE_BIT]) begin
                                ph_d = PH_IGNORE;
                            end
                        end
                        `OPC_CRM_RESET: begin
                            crm_kill = 1'b1;
                            ph_d = PH_IGNORE;
                        end
                        default: ph_d = PH_IGNORE;
                    endcase
                end
            end
            PH_ADDR: begin
                if (last) begin
                    ph_d = has_mode(eff_cmd) ? PH_MODE : PH_DUMMY;
                end
            end
            PH_MODE: begin
                if (last) begin
                    mode_done = 1'b1;
                    if (dummy_clks(eff_cmd) == 5'h00) begin
                        ph_d = PH_DATA;
                        start_byte = 1'b1;
                    end else begin
                        ph_d = PH_DUMMY;
                    end
                end
            end
            PH_DUMMY: begin
                if (last) begin
                    ph_d = PH_DATA;
                    start_byte = 1'b1;
                end
            end
            PH_DATA: begin
                if (last) begin
                    start_byte = 1'b1;
                end
            end
            default: ph_d = eff_ph;
        endcase
    end

    // Frame state; chip select high restarts phase, command, count and shifter
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            ph_q <= PH_START;
            cmd_q <= CMD_FAST;
            cnt_q <= 5'h00;
            sh_q <= 24'h000000;
        end else begin
            ph_q <= ph_d;
            cmd_q <= cmd_d;
            sh_q <= sh_d;
            if (last || (ph_d == PH_IGNORE)) begin
                cnt_q <= 5'h00;
            end else begin
                cnt_q <= 5'(cnt_q + 5'h01);
            end
        end
    end

    // Address pointer: load after address, advance at each byte start
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            mem_addr_q <= '0;
        end else if ((eff_ph == PH_ADDR) && last) begin
            mem_addr_q <= addr_full;
        end else if (start_byte) begin
            mem_addr_q <= next_addr(mem_addr_q, wrap_on,
                cfg_s[`CFG_WLEN_HI:`CFG_WLEN_LO]);
        end
    end

    // Array answers within one link clock; this stage prefetches
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            pre_q <= 8'h00;
            load_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            pre_q <= mem_rdata;
            load_q <= start_byte;
            busy_q <= (ph_d == PH_DATA);
        end
    end

    // Continuous mode survives chip select; only a clear or a mode byte ends it, since its frames skip the opcode and so the reset opcode
    always_ff @(posedge sclk or posedge link_clear_q) begin
        if (link_clear_q) begin
            crm_q <= 1'b0;
            crm_cmd_q <= CMD_QUAD_IO;
        end else if (crm_kill) begin
            crm_q <= 1'b0;
        end else if (mode_done) begin
            crm_q <= (sh_d[7:4] == `CRM_KEEP_NIBBLE);
            crm_cmd_q <= eff_cmd;
        end
    end

    assign mem_addr = mem_addr_q;

    // ======================================================================
    // Output lanes

    lane_if lif ();
    logic [3:0] lane_o;
    logic [3:0] lane_oe;

    assign lif.load = load_q;
    assign lif.byte_v = pre_q;
    assign lif.width = data_lanes(cmd_q);

    lane_driver u_drv (
        .sclk(sclk),
        .cs_n(cs_n),
        .lif(lif),
        .lane_o(lane_o),
        .lane_oe(lane_oe)
    );

    assign quad_lane_0_o = lane_o[0];
    assign quad_lane_1_o = lane_o[1];
    assign quad_lane_2_o = lane_o[2];
    assign quad_lane_3_o = lane_o[3];
    assign quad_lane_0_oe = lane_oe[0];
    assign quad_lane_1_oe = lane_oe[1];
    assign quad_lane_2_oe = lane_oe[2];
    assign quad_lane_3_oe = lane_oe[3];

endmodule : serial_flash_fast_read_engine

// ==== tb/flash_read_props.sv ====
`timescale 1ns/1ps
// ==========
// Port checker for the read engine
module flash_read_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic quad_lane_0_oe,
    input wire logic quad_lane_1_oe,
    input wire logic quad_lane_2_oe,
    input wire logic quad_lane_3_oe,
    input wire logic crm_clear,
    input wire logic read_active,
    input wire logic continuous_mode_active
);
    logic [3:0] oe;

    // Lane enables gathered, lane 3 on top
    assign oe = {quad_lane_3_oe, quad_lane_2_oe, quad_lane_1_oe,
                 quad_lane_0_oe};

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ==========
    // Steps of a read as seen at the pins
    sequence s_drv;
        oe != 4'h0 && !cs_n;
    endsequence
    sequence s_idle;
        cs_n [*4];
    endsequence

    property p_release;
        cs_n |-> oe == 4'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("lanes driven while deselected");
    property p_lanes;
        oe inside {4'h0, 4'h2, 4'h3, 4'hF};
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("illegal lane enable pattern");
    property p_hold;
        s_drv ##1 !cs_n |-> oe == $past(oe);
    endproperty
    a_hold: assert property (p_hold)
        else $error("lane enables moved inside a read");
    property p_start;
        $rose(read_active) && !cs_n |-> oe != 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("data phase without driven lanes");
    property p_active;
        s_drv [*5] |-> read_active;
    endproperty
    a_active: assert property (p_active)
        else $error("lanes driven outside a data phase");
    property p_idle;
        s_idle |=> !read_active;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read still active after deselect");
    property p_clear;
        crm_clear [*2] |-> ##[1:4] !continuous_mode_active;
    endproperty
    a_clear: assert property (p_clear)
        else $error("continuous mode survived a clear");
    // Reset itself is not masked here
    property p_reset;
        @(posedge mclk) disable iff (1'b0)
            !nrst |=> !read_active && !continuous_mode_active;
    endproperty
    a_reset: assert property (p_reset)
        else $error("status not cleared by reset");
endmodule : flash_read_props

bind serial_flash_fast_read_engine flash_read_props chk_u (.mclk, .nrst,
    .cs_n, .quad_lane_0_oe, .quad_lane_1_oe, .quad_lane_2_oe,
    .quad_lane_3_oe, .crm_clear, .read_active, .continuous_mode_active);

// ==== tb/flash_host_model.sv ====
`timescale 1ns/1ps
// ==========
// Host controller: makes the link clock only inside frames
module flash_host_model (
    output logic sclk,
    output logic cs_n,
    input wire logic [3:0] dut_o,
    input wire logic [3:0] dut_oe,
    output logic [3:0] lane
);
    logic [3:0] h_o = 4'h0;
    logic [3:0] h_oe = 4'h0;
    logic [3:0] junk = 4'h5;
    logic [3:0] acc;
    logic [3:0] oe_dum;
    logic [3:0] oe_dat;
    logic [7:0] rx[$];

    // Deselect pulse gives the frame logic a defined start
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        #1;
        cs_n = 1'b1;
    end

    // Released lanes toggle, so a stale level never passes for data
    always @(posedge sclk) junk <= ~junk;
    assign lane = (h_oe & h_o) | (~h_oe & dut_oe & dut_o)
                | (~h_oe & ~dut_oe & junk);

    // One link clock: change after the fall, sample before the rise
    task cyc(input logic [3:0] v, input logic [3:0] e,
             output logic [3:0] s);
        h_o = v;
        h_oe = e;
        #6;
        s = lane;
        acc = acc | dut_oe;
        sclk = 1'b1;
        #6;
        sclk = 1'b0;
    endtask : cyc

    task snd(input logic [31:0] d, input int nb, input int w);
        logic [3:0] s;
        logic [3:0] mk;
        mk = 4'((1 << w) - 1);
        for (int i = nb / w - 1; i >= 0; i--) begin
            cyc(4'(d >> (i * w)) & mk, mk, s);
        end
    endtask : snd

    task frame(input logic [7:0] op, input bit so, input logic [23:0] a,
               input int aw, input bit hm, input logic [7:0] m,
               input int dum, input int dw, input int n);
        logic [3:0] s;
        logic [3:0] mk;
        logic [7:0] b;
        mk = 4'((1 << dw) - 1);
        rx.delete();
        cs_n = 1'b0;
        if (so) snd({24'h0, op}, 8, 1);
        snd({8'h0, a}, 24, aw);
        if (hm) snd({24'h0, m}, 8, aw);
        acc = 4'h0;
        repeat (dum) cyc(4'h0, 4'h0, s);
        oe_dum = acc;
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < 8 / dw; j++) begin
                cyc(4'h0, 4'h0, s);
                b = (b << dw) | 8'(dw == 1 ? {3'h0, s[1]} : s & mk);
            end
            rx.push_back(b);
        end
        oe_dat = acc;
        #6;
        cs_n = 1'b1;
        #12;
    endtask : frame

    // Frame cut short inside the address
    task part();
        cs_n = 1'b0;
        snd(32'hEB, 8, 1);
        snd(32'h2AA, 16, 4);
        #6;
        cs_n = 1'b1;
        #12;
    endtask : part
endmodule : flash_host_model

// ==== tb/serial_flash_fast_read_engine_tb.sv ====
`timescale 1ns/1ps
module serial_flash_fast_read_engine_tb;
    logic mclk, nrst, sclk, cs_n, crm_clear, read_active;
    logic quad_enable_flag, wrap_disable_bit, continuous_mode_active;
    logic [1:0] wrap_length_field;
    logic [23:0] mem_addr, a;
    logic [7:0] mem_rdata;
    logic [3:0] lane, lo, loe;
    logic [7:0] ops [6] = '{8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7};
    int seed = 72108;
    int miscompares = 0;
    int checks_done = 0;
    int cyc_cnt = 0;

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Array content is a mix of its address
    function automatic logic [7:0] mem_f(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h3C;
    endfunction : mem_f
    assign mem_rdata = mem_f(mem_addr);

    serial_flash_fast_read_engine dut_u (.mclk, .nrst, .sclk, .cs_n,
        .quad_lane_0_i(lane[0]), .quad_lane_0_o(lo[0]), .quad_lane_0_oe(loe[0]),
        .quad_lane_1_i(lane[1]), .quad_lane_1_o(lo[1]), .quad_lane_1_oe(loe[1]),
        .quad_lane_2_i(lane[2]), .quad_lane_2_o(lo[2]), .quad_lane_2_oe(loe[2]),
        .quad_lane_3_i(lane[3]), .quad_lane_3_o(lo[3]), .quad_lane_3_oe(loe[3]),
        .quad_enable_flag, .wrap_disable_bit, .wrap_length_field, .crm_clear,
        .mem_addr, .mem_rdata, .read_active, .continuous_mode_active);
    flash_host_model host_u (.sclk, .cs_n, .dut_o(lo), .dut_oe(loe), .lane);

    task report_and_stop();
        if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task chk(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk

    // One frame against the reference stream of bytes
    task run(input logic [7:0] op, input bit so, input logic [23:0] sa,
             input logic [7:0] m, input int n, input bit ok);
        int aw, dw, dum, len;
        bit wr;
        logic [23:0] ea;
        aw = op == 8'hBB ? 2 : (op == 8'hEB || op == 8'hE7) ? 4 : 1;
        dw = op == 8'h3B ? 2 : op == 8'h6B ? 4 : aw;
        dum = op == 8'hBB ? 0 : op == 8'hEB ? 4 : op == 8'hE7 ? 2 : 8;
        wr = aw == 4 && !wrap_disable_bit;
        len = 8 << wrap_length_field;
        ea = op == 8'hE7 ? {sa[23:1], 1'b0} : sa;
        host_u.frame(op, so, ea, aw, aw > 1, m, dum, dw, n);
        chk(8'h00, {4'h0, host_u.oe_dum});
        if (!ok) chk(8'h00, {4'h0, host_u.oe_dat});
        for (int i = 0; ok && i < n; i++) begin
            chk(mem_f(ea), host_u.rx[i]);
            ea = wr ? (ea & ~24'(len - 1)) | ((ea + 24'h1) & 24'(len - 1))
                    : ea + 24'h1;
        end
    endtask : run

    task mode_is(input logic v);
        repeat (6) @(posedge mclk);
        chk({7'h0, v}, {7'h0, continuous_mode_active});
    endtask : mode_is

    // Hang guard
    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ==========
    // Main sequence
    initial begin
        nrst = 1'b0;
        crm_clear = 1'b0;
        quad_enable_flag = 1'b0;
        wrap_disable_bit = 1'b1;
        wrap_length_field = 2'h0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        quad_enable_flag <= 1'b1;
        repeat (4) @(posedge mclk);
        run(8'hA3, 1'b1, 24'h000000, 8'h00, 1, 1'b0);
        foreach (ops[i]) begin
            a = 24'($random(seed));
            run(ops[i], 1'b1, a, 8'h00, 5, 1'b1);
        end
        run(8'h0B, 1'b1, 24'hFFFFFE, 8'h00, 4, 1'b1);
        for (int i = 3; i < 6; i++) begin
            run(ops[i], 1'b1, a, 8'hA5, 3, 1'b1);
            mode_is(1'b1);
            run(ops[i], 1'b0, a + 24'h40, 8'h3A, 3, 1'b1);
            mode_is(1'b0);
            run(ops[i], 1'b1, a, 8'h00, 2, 1'b1);
        end
        run(8'hEB, 1'b1, a, 8'hAF, 2, 1'b1);
        @(posedge mclk);
        crm_clear <= 1'b1;
        repeat (3) @(posedge mclk);
        crm_clear <= 1'b0;
        mode_is(1'b0);
        run(8'hEB, 1'b1, a, 8'h00, 2, 1'b1);
        // Refusals: quad reads without enable, unknown and reset codes
        @(posedge mclk);
        quad_enable_flag <= 1'b0;
        @(posedge mclk);
        run(8'hEB, 1'b1, a, 8'h00, 2, 1'b0);
        run(8'hE7, 1'b1, a, 8'h00, 2, 1'b0);
        run(8'h03, 1'b1, a, 8'h00, 2, 1'b0);
        run(8'hFF, 1'b1, a, 8'h00, 2, 1'b0);
        @(posedge mclk);
        quad_enable_flag <= 1'b1;
        wrap_disable_bit <= 1'b0;
        for (int l = 0; l < 4; l++) begin
            @(posedge mclk);
            wrap_length_field <= 2'(l);
            @(posedge mclk);
            a = 24'($random(seed));
            run(8'hEB, 1'b1, a, 8'h00, (8 << l) + 3, 1'b1);
            run(8'hE7, 1'b1, a, 8'h00, (8 << l) + 3, 1'b1);
            run(8'h0B, 1'b1, a, 8'h00, (8 << l) + 3, 1'b1);
        end
        @(posedge mclk);
        wrap_disable_bit <= 1'b1;
        @(posedge mclk);
        run(8'hEB, 1'b1, 24'h0000FC, 8'h00, 10, 1'b1);
        host_u.part();
        run(8'h6B, 1'b1, a, 8'h00, 3, 1'b1);
        report_and_stop();
    end
endmodule : serial_flash_fast_read_engine_tb
